//--- inc/i2csam_pkg.sv
// Shared constants and types of the slave address match block.
// Assumes a 32-bit AXI4-Lite register bus; each register takes one word.
package i2csam_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_PIR = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_BUF = 10'h013;
  localparam logic [IDX_W-1:0] IDX_CON = 10'h014;
  localparam logic [IDX_W-1:0] IDX_PIE = 10'h08c;
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h094;
  localparam logic [IDX_W-1:0] IDX_SADD = 10'h030;
  localparam logic [IDX_W-1:0] IDX_EVT = 10'h031;
  localparam logic [IDX_W-1:0] IDX_EMASK = 10'h032;
  // Field positions.
  localparam int unsigned PIR_PORT_IF = 3;
  localparam int unsigned CON_WCOL = 7;
  localparam int unsigned CON_OV = 6;
  localparam int unsigned CON_EN = 5;
  localparam int unsigned CON_TEN = 0;
  localparam int unsigned STAT_DA = 5;
  localparam int unsigned STAT_P = 4;
  localparam int unsigned STAT_S = 3;
  localparam int unsigned STAT_RW = 2;
  localparam int unsigned STAT_UA = 1;
  localparam int unsigned STAT_BF = 0;
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_MATCH = 0;
  localparam int unsigned EVT_UA = 1;
  localparam int unsigned EVT_REFUSE = 2;
  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;
  // Protocol constants.
  localparam logic [4:0] TEN_BIT_ID = 5'h1e;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SHIFT = 4'h2,
    ST_ACK = 4'h4,
    ST_DONE = 4'h8
  } i2csam_state_t;
endpackage

//--- logic/i2csam_cond.sv
// Finds SCL edges and START and STOP conditions on synchronised levels.
// Assumes scl and sda already passed a synchroniser.
`timescale 1ns/1ps
module i2csam_cond (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  typedef struct packed {
    logic scl_q;
    logic sda_q;
  } i2csam_cond_t;
  i2csam_cond_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.scl_q = scl;
    s_next.sda_q = sda;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign scl_rise = scl && !s_reg.scl_q;
  assign scl_fall = !scl && s_reg.scl_q;
  assign start_seen = scl && s_reg.scl_q && s_reg.sda_q && !sda;
  assign stop_seen = scl && s_reg.scl_q && !s_reg.sda_q && sda;
endmodule // i2csam_cond

//--- logic/i2csam_sync.sv
// Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes the inputs change slowly against aclk.
`timescale 1ns/1ps
module i2csam_sync #(
  parameter int unsigned W = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } i2csam_sync_t;
  i2csam_sync_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.meta = d;
    s_next.sync = s_reg.meta;
  end
  // Pins idle high on an open-drain bus.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign q = s_reg.sync;
endmodule // i2csam_sync

//--- logic/i2csam_top.sv
// I2C slave address reception with 7-bit and 10-bit address match.
// Assumes an AXI4-Lite master and an open-drain bus resolved outside.
//
// Notes on behaviour
// RULE1: when enabled, after START shift eight bits in.
// RULE2: sample each address bit on SCL rise.
// RULE3: compare shift bits 7:1 at eighth falling edge.
// RULE4: match and no overflow: buffer, full, ACK. The code also requires the full flag clear.
// RULE5: matched byte sets interrupt flag at ninth fall.
// RULE6: 10-bit mode takes two address bytes.
// RULE7: first 10-bit byte is 11110, A9, A8, 0.
// RULE8: master writes first byte so second follows.
// RULE9: high byte sets interrupt, full, update flags.
// RULE10: update flag holds SCL; address write releases.
// RULE11: buffer read clears full; software clears flag.
// RULE12: after low byte, software reloads high address.
// RULE13: repeated START re-accepts high byte, sets flags.
// RULE14: overflow blocks ACK and buffer load.
// RULE15: interrupt flag set even for refused bytes.
// RULE16: matched write address clears read/write status.
// RULE17: ACK holds SDA low through ninth pulse.
// RULE18: disabled module ignores bus, releases lines.
`timescale 1ns/1ps
module i2csam_top
  import i2csam_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  typedef struct packed {
    i2csam_state_t state;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic [7:0] rbuf;
    logic [7:0] sadd;
    logic [7:0] con;
    logic [7:0] stat;
    logic [7:0] pir;
    logic [7:0] pie;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] emask;
    logic hit;
    logic go_low;
    logic phase_low;
    logic ten_done;
    logic ack_drv;
    logic hold;
    logic pin_lvl;
    logic irq;
    logic awready;
    logic awgot;
    logic [IDX_W-1:0] awidx;
    logic wready;
    logic wgot;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } i2csam_st_t;

  i2csam_st_t s_reg, s_next;
  logic [1:0] pins_sync;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  i2csam_sync #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({scl_i, sda_i}),
    .q(pins_sync)
  );

  i2csam_cond u_cond (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl(pins_sync[1]),
    .sda(pins_sync[0]),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  // Returns the error flag above the read data byte.
  function automatic logic [8:0] rd_mux(input logic [IDX_W-1:0] a,
                                        input i2csam_st_t q);
    logic [8:0] r;
    r = {1'b0, RST_BYTE};
    case (a)
      IDX_PIR: r[7:0] = q.pir;
      IDX_BUF: r[7:0] = q.rbuf;
      IDX_CON: r[7:0] = q.con;
      IDX_PIE: r[7:0] = q.pie;
      IDX_STAT: r[7:0] = q.stat;
      IDX_SADD: r[7:0] = q.sadd;
      IDX_EVT: r[EVT_W-1:0] = q.evt;
      IDX_EMASK: r[EVT_W-1:0] = q.emask;
      default: r[8] = 1'b1;
    endcase
    return r;
  endfunction

  always_comb begin
    logic [8:0] rd;
    logic free;
    logic ten;
    logic [IDX_W-1:0] ridx;
    rd = '0;
    free = 1'b0;
    ten = 1'b0;
    ridx = s_axi_araddr[ADDR_W-1:2];
    s_next = s_reg;

    // Write channel: address and data taken in either order.
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.awready = 1'b0;
      s_next.awgot = 1'b1;
      s_next.awidx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.wready = 1'b0;
      s_next.wgot = 1'b1;
      s_next.wbyte = s_axi_wdata[7:0];
      s_next.wlane = s_axi_wstrb[0];
    end
    if (s_reg.awgot && s_reg.wgot) begin
      s_next.awgot = 1'b0;
      s_next.wgot = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      case (s_reg.awidx)
        IDX_PIR: if (s_reg.wlane) s_next.pir = s_reg.wbyte; // see RULE11
        IDX_BUF: ;
        IDX_CON: if (s_reg.wlane) s_next.con = s_reg.wbyte;
        IDX_PIE: if (s_reg.wlane) s_next.pie = s_reg.wbyte;
        IDX_STAT: begin
          if (s_reg.wlane) begin
            s_next.stat[7:6] = s_reg.wbyte[7:6];
          end
        end
        IDX_SADD: begin
          if (s_reg.wlane) begin
            s_next.sadd = s_reg.wbyte;
            s_next.stat[STAT_UA] = 1'b0; // see RULE10
          end
        end
        IDX_EVT: ;
        IDX_EMASK: begin
          if (s_reg.wlane) begin
            s_next.emask = s_reg.wbyte[EVT_W-1:0];
          end
        end
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end

    // Read channel: answer in the cycle after the address is taken.
    if (s_axi_arvalid && s_reg.arready) begin
      rd = rd_mux(ridx, s_reg);
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = rd[7:0];
      s_next.rresp = rd[8] ? RESP_SLVERR : RESP_OKAY;
      if (ridx == IDX_BUF) begin
        s_next.stat[STAT_BF] = 1'b0; // see RULE11
      end
      if (ridx == IDX_EVT) begin
        s_next.evt = RST_EVT;
      end
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end

    // Bus side; placed after software so a hardware set wins a clear.
    ten = s_reg.con[CON_TEN];
    free = !s_reg.stat[STAT_BF] && !s_reg.con[CON_OV];
    if (!s_reg.con[CON_EN]) begin
      s_next.state = ST_IDLE; // see RULE18
      s_next.ack_drv = 1'b0;
      s_next.hold = 1'b0;
      s_next.phase_low = 1'b0;
      s_next.ten_done = 1'b0;
    end else if (start_seen) begin
      s_next.state = ST_SHIFT; // see RULE1
      s_next.cnt = '0;
      s_next.ack_drv = 1'b0;
      s_next.stat[STAT_S] = 1'b1;
      s_next.stat[STAT_P] = 1'b0;
    end else if (stop_seen) begin
      s_next.state = ST_IDLE;
      s_next.ack_drv = 1'b0;
      s_next.phase_low = 1'b0;
      s_next.ten_done = 1'b0;
      s_next.stat[STAT_P] = 1'b1;
      s_next.stat[STAT_S] = 1'b0;
    end else begin
      case (s_reg.state)
        ST_IDLE: ;
        ST_SHIFT: begin
          if (scl_rise && s_reg.cnt < BITS_PER_BYTE) begin
            s_next.sr = {s_reg.sr[6:0], pins_sync[0]}; // see RULE2
            s_next.cnt = s_reg.cnt + 4'h1;
          end
          if (scl_fall && s_reg.cnt == BITS_PER_BYTE) begin
            s_next.state = ST_ACK;
            s_next.go_low = 1'b0;
            if (!ten) begin
              s_next.hit = s_reg.sr[7:1] == s_reg.sadd[7:1]; // see RULE3
            end else if (s_reg.phase_low) begin
              s_next.hit = s_reg.sr == s_reg.sadd; // see RULE12
            end else begin
              // A read bit on the high byte counts only once addressed.
              s_next.hit = s_reg.sr[7:3] == TEN_BIT_ID && // see RULE7
                           s_reg.sr[2:1] == s_reg.sadd[2:1] &&
                           (!s_reg.sr[0] || s_reg.ten_done); // see RULE8
              s_next.go_low = !s_reg.ten_done; // see RULE6
            end
            if (s_next.hit) begin
              if (free) begin
                s_next.rbuf = s_reg.sr; // see RULE4
                s_next.stat[STAT_BF] = 1'b1;
                s_next.ack_drv = 1'b1; // see RULE17
                s_next.stat[STAT_RW] = s_reg.sr[0]; // see RULE16
                s_next.stat[STAT_DA] = 1'b0;
                if (ten && !(s_next.go_low == 1'b0 && s_reg.ten_done
                             && !s_reg.phase_low)) begin
                  s_next.stat[STAT_UA] = 1'b1; // see RULE9
                  s_next.evt[EVT_UA] = 1'b1;
                end
                if (ten && s_reg.phase_low) begin
                  s_next.ten_done = 1'b1;
                end
              end else begin
                s_next.con[CON_OV] = s_reg.stat[STAT_BF] |
                                     s_reg.con[CON_OV]; // see RULE14
                s_next.go_low = 1'b0;
                s_next.evt[EVT_REFUSE] = 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            s_next.ack_drv = 1'b0;
            s_next.cnt = '0;
            if (s_reg.hit) begin
              s_next.pir[PIR_PORT_IF] = 1'b1; // see RULE5 RULE15
              s_next.evt[EVT_MATCH] = 1'b1;
              s_next.hold = s_reg.stat[STAT_UA]; // see RULE10
            end
            s_next.phase_low = s_reg.hit && s_reg.go_low;
            // After repeated START the high byte ends addressing.
            s_next.state = (s_reg.hit && s_reg.go_low) ? ST_SHIFT
                                                       : ST_DONE; // see RULE13
          end
        end
        ST_DONE: ;
        default: s_next.state = ST_IDLE;
      endcase
    end
    if (!s_next.stat[STAT_UA]) begin
      s_next.hold = 1'b0; // see RULE10
    end
    s_next.pin_lvl = 1'b0;
    s_next.irq = (|(s_next.evt & s_next.emask)) ||
                 (s_next.pir[PIR_PORT_IF] && s_next.pie[PIR_PORT_IF]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.con <= RST_BYTE;
      s_reg.stat <= RST_BYTE;
      s_reg.pir <= RST_BYTE;
      s_reg.pie <= RST_BYTE;
      s_reg.evt <= RST_EVT;
      s_reg.emask <= RST_EVT;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = {24'h00_0000, s_reg.rdata};
  assign scl_o = s_reg.pin_lvl;
  assign sda_o = s_reg.pin_lvl;
  assign scl_oe = s_reg.hold;
  assign sda_oe = s_reg.ack_drv;
  assign irq = s_reg.irq;
endmodule // i2csam_top

//--- verification/i2csam_mstr.sv
// Behavioural I2C bus master on open-drain SCL and SDA.
// Assumes pull-ups outside; a high low-output pulls its wire down.
`timescale 1ns/1ps
module i2csam_mstr (
  input wire logic aclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  // Three aclk cycles plus one edge per phase give a 400 ns SCL period.
  int half = 3;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic wait_half();
    repeat (half) @(posedge aclk);
  endtask
  // Releases SCL and waits while the slave stretches it.
  task automatic rise_scl();
    scl_low <= 1'b0;
    do begin
      @(posedge aclk);
    end while (!scl);
    wait_half();
  endtask
  task automatic start();
    sda_low <= 1'b0;
    wait_half();
    rise_scl();
    sda_low <= 1'b1;
    wait_half();
    scl_low <= 1'b1;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      @(posedge aclk);
      sda_low <= !b[i];
      wait_half();
      rise_scl();
      scl_low <= 1'b1;
    end
    @(posedge aclk);
    sda_low <= 1'b0;
    wait_half();
    rise_scl();
    ack = !sda;
    scl_low <= 1'b1;
    wait_half();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    wait_half();
    rise_scl();
    sda_low <= 1'b0;
    wait_half();
  endtask
endmodule // i2csam_mstr

//--- verification/i2csam_top_checker.sv
// Concurrent checks on the bus pins of the address match block.
// Assumes a bind onto i2csam_top; it sees only that module's ports.
`timescale 1ns/1ps
module i2csam_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic s_axi_bvalid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence ack_begin;
    $rose(sda_oe) ##0 !scl_i;
  endsequence
  sequence ninth_rise;
    $rose(scl_i) ##0 sda_oe;
  endsequence
  a_ack_pulls_low: assert property (sda_oe |-> !sda_o)
    else $error("acknowledge drives SDA high");
  a_hold_pulls_low: assert property (scl_oe |-> !scl_o)
    else $error("clock hold drives SCL high");
  a_ack_on_low: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("acknowledge starts while SCL is high");
  a_ack_covers_slot: assert property (ack_begin |=> sda_oe [*4])
    else $error("acknowledge dropped before the ninth pulse");
  a_ack_high_hold: assert property (ninth_rise |=> sda_oe [*3])
    else $error("acknowledge released during SCL high");
  a_ack_end_low: assert property ($fell(sda_oe) |-> !scl_i)
    else $error("acknowledge released while SCL is high");
  a_hold_stays: assert property ($rose(scl_oe) |=> scl_oe [*8])
    else $error("clock hold released without a write");
  a_release_on_write: assert property (
    $fell(scl_oe) |-> s_axi_bvalid)
    else $error("clock hold released with no register write");
endmodule // i2csam_top_checker

//--- verification/i2csam_top_tb_top.sv
// Self-checking bench for the I2C slave address match block.
// Assumes the checker and the master model are compiled before it.
`timescale 1ns/1ps
module i2csam_top_tb_top;
  import i2csam_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda, ack;
  logic [7:0] rv;
  int n_errors = 0;
  int n_tests = 0;
  wire scl_i = !(m_scl || (scl_oe && !scl_o));
  wire sda_i = !(m_sda || (sda_oe && !sda_o));
  always #25 aclk = ~aclk;
  i2csam_top u_i2csam_top (.*);
  i2csam_mstr u_i2csam_mstr (.aclk(aclk), .scl(scl_i), .sda(sda_i),
    .scl_low(m_scl), .sda_low(m_sda));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [1:0] resp_of(input logic [IDX_W-1:0] i);
    return (i == 10'h3ff) ? RESP_SLVERR : RESP_OKAY;
  endfunction
  task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(resp_of(i)));
  endtask
  task automatic rd(input logic [IDX_W-1:0] i);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata[7:0];
    chk(32'(s_axi_rresp), 32'(resp_of(i)));
  endtask
  task automatic rc(input logic [IDX_W-1:0] i, input logic [7:0] m,
                    input logic [7:0] e);
    rd(i);
    chk(32'(rv & m), 32'(e));
  endtask
  // The pin is passed by reference so that its value after the wait counts.
  task automatic pin(ref logic p, input logic e);
    repeat (2) @(posedge aclk);
    chk(32'(p), 32'(e));
  endtask
  task automatic xfer(input logic s, input logic [7:0] b, input logic e,
                      input logic p);
    if (s) u_i2csam_mstr.start();
    u_i2csam_mstr.send(b, ack);
    chk(32'(ack), 32'(e));
    if (p) u_i2csam_mstr.stop();
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // About ten bytes of 100 cycles plus register traffic fit easily.
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(IDX_PIR, 8'hff, 8'h00);
    rc(IDX_CON, 8'hff, 8'h00);
    rc(IDX_PIE, 8'hff, 8'h00);
    rc(IDX_STAT, 8'hff, 8'h00);
    rd(10'h3ff);
    wr(10'h3ff, 8'h00);
    wr(IDX_PIE, 8'h08);
    wr(IDX_SADD, 8'ha4);
    xfer(1'b1, 8'ha4, 1'b0, 1'b1);
    rc(IDX_PIR, 8'h08, 8'h00);
    wr(IDX_CON, 8'h20);
    xfer(1'b1, 8'ha4, 1'b1, 1'b1);
    pin(irq, 1'b1);
    rc(IDX_PIR, 8'h08, 8'h08);
    rc(IDX_STAT, 8'h07, 8'h01);
    rc(IDX_BUF, 8'hff, 8'ha4);
    rc(IDX_STAT, 8'h01, 8'h00);
    wr(IDX_PIR, 8'h00);
    pin(irq, 1'b0);
    wr(IDX_EMASK, 8'h01);
    pin(irq, 1'b1);
    rc(IDX_EVT, 8'h07, 8'h01);
    pin(irq, 1'b0);
    wr(IDX_EMASK, 8'h00);
    // Refused while full, then while only the overflow flag is set.
    xfer(1'b1, 8'ha4, 1'b1, 1'b1);
    xfer(1'b1, 8'ha5, 1'b0, 1'b1);
    rc(IDX_PIR, 8'h08, 8'h08);
    rc(IDX_CON, 8'h40, 8'h40);
    rc(IDX_BUF, 8'hff, 8'ha4);
    wr(IDX_PIR, 8'h00);
    xfer(1'b1, 8'ha4, 1'b0, 1'b1);
    rc(IDX_PIR, 8'h08, 8'h08);
    wr(IDX_CON, 8'h20);
    wr(IDX_PIR, 8'h00);
    xfer(1'b1, 8'h50, 1'b0, 1'b1);
    rc(IDX_PIR, 8'h08, 8'h00);
    // Ten-bit address: high byte, low byte, then repeated start.
    wr(IDX_CON, 8'h21);
    wr(IDX_SADD, 8'hf2);
    xfer(1'b1, 8'hf3, 1'b0, 1'b1);
    rc(IDX_PIR, 8'h08, 8'h00);
    xfer(1'b1, 8'hf2, 1'b1, 1'b0);
    pin(scl_oe, 1'b1);
    rc(IDX_STAT, 8'h03, 8'h03);
    rc(IDX_PIR, 8'h08, 8'h08);
    rc(IDX_BUF, 8'hff, 8'hf2);
    wr(IDX_PIR, 8'h00);
    pin(scl_oe, 1'b1);
    wr(IDX_SADD, 8'h34);
    pin(scl_oe, 1'b0);
    rc(IDX_STAT, 8'h02, 8'h00);
    xfer(1'b0, 8'h34, 1'b1, 1'b0);
    pin(scl_oe, 1'b1);
    rc(IDX_STAT, 8'h03, 8'h03);
    rc(IDX_BUF, 8'hff, 8'h34);
    wr(IDX_PIR, 8'h00);
    wr(IDX_SADD, 8'hf2);
    pin(scl_oe, 1'b0);
    xfer(1'b1, 8'hf3, 1'b1, 1'b1);
    rc(IDX_STAT, 8'h07, 8'h05);
    rc(IDX_PIR, 8'h08, 8'h08);
    wr(IDX_PIE, 8'h00);
    pin(irq, 1'b0);
    finish_test();
  end
endmodule // i2csam_top_tb_top
bind i2csam_top i2csam_top_checker u_i2csam_top_checker (.*);
